//--- rtl/cuc_elapsed_time_generator.sv
// Local time generator: rate synthesizer, elapsed time counter, time-code
// source and interval filter for received time-codes.
// Assumes every input is logic on the same system clock, so none is
// synchronised; a processor or link node drives the setting ports.
//
// Notes on behaviour
// R1: Counter advances only on synthesizer tick.
// R2: Synthesizer adds its increment every cycle.
// R3: Wrap gives one-cycle tick, adds time increment.
// R4: Both increments are programmable.
// R5: Time field is cascaded modulo-256 octet counters.
// R6: Coarse seconds, eight to fifty-six bits.
// R7: Fine fraction, zero to eighty bits.
// R8: Coarse counts plain seconds, no calendar.
// R9: Preamble field reports coarse and fine widths.
// R10: Preamble bit0 one, bits1-3 are 010.
// R11: Bits4-5 coarse octets minus one, 6-7 fine.
// R12: Bit8 zero, additional octets, reserved 14-15.
// R13: Field numbered most significant bit first.
// R14: Master hands time-codes to link interface.
// R15: Only one time master per phase.
// R16: Master writes qualifying code before sending.
// R17: Each target gets its own write.
// R18: Settings and status reach a control port.
// R19: Average received intervals into jitter-free tick.
// R20: Time-code on mapped bits change, lower zero.
// R21: Mapping clamped to fine width; halves interval.
// R22: Counter wraps on overflow, clear until loaded.
`timescale 1ns/1ns
module cuc_elapsed_time_generator (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Rate and mapping settings from the control processor.
  input wire logic [cuc_pkg::SYNTH_W-1:0] synth_inc,
  input wire logic [cuc_pkg::ET_W-1:0] et_inc,
  input wire logic [cuc_pkg::MAP_W-1:0] mapping,
  input wire logic master_en,
  // Initial time load.
  input wire logic load_time,
  input wire logic [cuc_pkg::ET_W-1:0] load_value,
  // Time-codes received by the link node.
  input wire logic tc_rx_strobe,
  // Time-codes handed to the link node.
  output logic tc_tx_strobe,
  output logic [cuc_pkg::TC_W-1:0] tc_tx_value,
  // Local time and status.
  output logic [cuc_pkg::ET_W-1:0] elapsed_time,
  output logic [cuc_pkg::PRE_W-1:0] datation_width_field,
  output logic initialized,
  output logic synth_tick,
  output logic [cuc_pkg::MAP_W-1:0] mapping_used,
  // Interval filter results.
  output logic [cuc_pkg::CNT_W-1:0] avg_interval,
  output logic filter_locked,
  output logic corr_tick
);
  import cuc_pkg::*;

  // Mapping limit at the width of the mapping setting.
  localparam logic [MAP_W-1:0] MAP_MAX = MAP_W'(FINE_W);

  // Synthesizer link.
  cuc_synth_if sif ();

  // Elapsed time state.
  logic [ET_W-1:0] et_reg;
  logic [ET_W-1:0] et_next;
  logic init_reg;
  logic init_next;
  wire [ET_W-1:0] et_sum;
  wire [OCT_COUNT:0] carry;
  wire et_step;

  // Preamble holding register.
  logic [PRE_W-1:0] pre_reg;

  // Time-code source state.
  logic [TC_W-1:0] tc_last_reg;
  logic [TC_W-1:0] tc_val_reg;
  logic [TC_W-1:0] tc_val_next;
  logic tc_stb_reg;
  wire [MAP_W-1:0] map_eff;
  wire [MAP_W-1:0] shift;
  wire [ET_W-1:0] et_shifted;
  wire [ET_W-1:0] low_mask;
  wire [TC_W-1:0] tc_cur;
  wire low_zero;
  wire tc_changed;
  wire tc_emit;

  // Interval filter state.
  cuc_jit_state_t jit_reg;
  cuc_jit_state_t jit_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] avg_reg;
  logic [CNT_W-1:0] avg_next;
  logic [CNT_W-1:0] ph_reg;
  logic [CNT_W-1:0] ph_next;
  logic ctick_reg;
  logic ctick_next;
  wire cnt_full;
  wire signed [CNT_W:0] diff;
  wire signed [CNT_W:0] step;
  wire [CNT_W-1:0] avg_upd;
  wire [CNT_W-1:0] avg_safe;
  wire ph_end;

  // The rate synthesizer lives in its own module so its wrap logic stays
  // apart from the wide time arithmetic.
  cuc_rate_synth u_synth (
    .clk(clk),
    .reset(reset),
    .sif(sif.rate)
  );

  // Software sets the synthesizer step directly.
  assign sif.inc = synth_inc; // [R4] [R18]
  assign et_step = sif.tick && init_reg; // [R1] [R3]

  // Each octet is its own modulo-256 counter; the carry out of one feeds
  // the next. The carry out of the top octet is dropped, so the whole
  // field wraps to zero on overflow.
  assign carry[0] = 1'b0;
  for (genvar g = 0; g < OCT_COUNT; g++) begin : g_oct
    wire [OCT_W:0] oct_sum;
    assign oct_sum = {1'b0, et_reg[g*OCT_W +: OCT_W]} + {1'b0, et_inc[g*OCT_W +: OCT_W]}
                     + {{OCT_W{1'b0}}, carry[g]}; // [R5] [R4]
    assign et_sum[g*OCT_W +: OCT_W] = oct_sum[OCT_W-1:0];
    assign carry[g+1] = oct_sum[OCT_W]; // [R22]
  end

  // Next time value: a load wins over a step, and the counter holds
  // otherwise. Coarse time is a plain binary second count.
  always_comb begin
    et_next = et_reg;
    init_next = init_reg;
    if (load_time) begin
      et_next = load_value; // [R8]
      init_next = 1'b1;
    end else if (et_step) begin
      et_next = et_sum; // [R1] [R3]
    end
  end

  // Counter clears on reset and stays cleared until a time is loaded.
  always_ff @(posedge clk) begin
    if (reset) begin
      et_reg <= ET_RESET; // [R22]
      init_reg <= 1'b0;
    end else begin
      et_reg <= et_next;
      init_reg <= init_next;
    end
  end

  // The width field is constant, but it is held in a register so the
  // output reads zero during reset like the other register-fed data outputs.
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_reg <= PRE_RESET;
    end else begin
      pre_reg <= PREAMBLE; // [R9] [R10] [R11] [R12]
    end
  end

  // A mapping beyond the fine width would select bits that do not exist,
  // so it is held at the fine width.
  assign map_eff = (mapping > MAP_MAX) ? MAP_MAX : mapping; // [R21]

  // Bit 0 of the field is the most significant counter bit, so the six
  // mapped positions end at the last coarse bit plus the mapping. Counting
  // from the least significant end that is a right shift by the fine
  // width less the mapping.
  assign shift = MAP_MAX - map_eff; // [R13]
  assign et_shifted = et_reg >> shift;
  assign tc_cur = et_shifted[TC_W-1:0]; // [R20]

  // Every bit of lower weight than the mapped ones must be zero.
  assign low_mask = ~({ET_W{1'b1}} << shift);
  assign low_zero = (et_reg & low_mask) == ET_RESET; // [R20]

  // A change of the mapped bits with the lower bits zero is a boundary.
  // A change of mapping itself can also produce one such code; software
  // should change the mapping only while the master is disabled.
  assign tc_changed = tc_cur != tc_last_reg;
  assign tc_emit = master_en && init_reg && low_zero && tc_changed; // [R14] [R20]
  assign tc_val_next = tc_emit ? tc_cur : tc_val_reg;

  // The last mapped value follows the counter every cycle, so a counter
  // that holds between synthesizer ticks never repeats a code.
  always_ff @(posedge clk) begin
    if (reset) begin
      tc_last_reg <= TC_RESET;
      tc_val_reg <= TC_RESET;
      tc_stb_reg <= 1'b0;
    end else begin
      tc_last_reg <= tc_cur;
      tc_val_reg <= tc_val_next;
      tc_stb_reg <= tc_emit; // [R14]
    end
  end

  // The interval counter saturates, so a lost link gives a long interval
  // instead of a short wrapped one.
  assign cnt_full = cnt_reg == {CNT_W{1'b1}};

  // Running average moves an eighth of the error per interval; a slower
  // filter rejects more jitter but follows drift more slowly.
  assign diff = $signed({1'b0, cnt_reg}) - $signed({1'b0, avg_reg});
  assign step = diff >>> AVG_SHIFT;
  assign avg_upd = avg_reg + step[CNT_W-1:0]; // [R19]

  // A zero period would stall the local tick, so one is the floor.
  assign avg_safe = (avg_reg == CNT_RESET) ? CNT_ONE : avg_reg;

  // The local tick ends a period when the phase counter reaches one.
  assign ph_end = ph_reg <= CNT_ONE;

  // Interval filter: the first strobe starts timing, the second sets the
  // average, and later ones refine it.
  always_comb begin
    jit_next = jit_reg;
    avg_next = avg_reg;
    cnt_next = cnt_full ? cnt_reg : cnt_reg + CNT_ONE;
    case (jit_reg)
      JIT_IDLE: begin
        cnt_next = CNT_RESET;
        if (tc_rx_strobe) begin
          cnt_next = CNT_ONE;
          jit_next = JIT_FIRST;
        end
      end
      JIT_FIRST: begin
        if (tc_rx_strobe) begin
          avg_next = cnt_reg; // [R19]
          cnt_next = CNT_ONE;
          jit_next = JIT_TRACK;
        end
      end
      JIT_TRACK: begin
        if (tc_rx_strobe) begin
          avg_next = avg_upd; // [R19]
          cnt_next = CNT_ONE;
        end
      end
      default: begin
        jit_next = JIT_IDLE;
        cnt_next = CNT_RESET;
      end
    endcase
  end

  // Local corrected tick: a free running divider by the averaged period.
  // It is never realigned to a received strobe, which is what keeps the
  // link jitter out of it; its period follows the integer average, which
  // moves by an eighth of the error at each received strobe.
  always_comb begin
    ph_next = ph_reg;
    ctick_next = 1'b0;
    if (jit_reg == JIT_FIRST && tc_rx_strobe) begin
      ph_next = cnt_reg; // [R19]
    end else if (jit_reg == JIT_TRACK) begin
      if (ph_end) begin
        ph_next = avg_safe;
        ctick_next = 1'b1; // [R19]
      end else begin
        ph_next = ph_reg - CNT_ONE;
      end
    end
  end

  // Filter registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      jit_reg <= JIT_IDLE;
      cnt_reg <= CNT_RESET;
      avg_reg <= CNT_RESET;
    end else begin
      jit_reg <= jit_next;
      cnt_reg <= cnt_next;
      avg_reg <= avg_next;
    end
  end

  // Local tick registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      ph_reg <= CNT_RESET;
      ctick_reg <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      ctick_reg <= ctick_next;
    end
  end

  // Outputs; all data except mapping_used and filter_locked comes straight from registers.
  assign elapsed_time = et_reg;
  assign datation_width_field = pre_reg;
  assign initialized = init_reg;
  assign synth_tick = sif.tick;
  assign mapping_used = map_eff;
  assign tc_tx_strobe = tc_stb_reg;
  assign tc_tx_value = tc_val_reg;
  assign avg_interval = avg_reg;
  assign filter_locked = jit_reg == JIT_TRACK;
  assign corr_tick = ctick_reg;

endmodule

//--- rtl/cuc_pkg.sv
// Shared constants for the elapsed time generator and its rate synthesizer.
// Assumes one system clock; widths are fixed at the implemented values.
package cuc_pkg;

  // Time field widths in bits.
  localparam int COARSE_W = 32; // [R6]
  localparam int FINE_W = 24; // [R7]
  localparam int ET_W = COARSE_W + FINE_W;
  localparam int OCT_W = 8;
  localparam int OCT_COUNT = ET_W / OCT_W;

  // Synthesizer, mapping and interval counter widths.
  localparam int SYNTH_W = 32;
  localparam int MAP_W = 5;
  localparam int TC_W = 6;
  localparam int CNT_W = 32;
  localparam int AVG_SHIFT = 3;

  // Preamble octet counts; the first octet holds at most four coarse and three fine octets.
  localparam int COARSE_OCT = COARSE_W / OCT_W;
  localparam int FINE_OCT = FINE_W / OCT_W;
  localparam int C_FIRST = (COARSE_OCT > 4) ? 4 : COARSE_OCT;
  localparam int C_ADD = COARSE_OCT - C_FIRST;
  localparam int F_FIRST = (FINE_OCT > 3) ? 3 : FINE_OCT;
  localparam int F_ADD = FINE_OCT - F_FIRST;
  localparam int PRE_W = 16;

  // Preamble word, leftmost bit is preamble bit 0.
  localparam logic [PRE_W-1:0] PREAMBLE = {1'b1, 3'b010, 2'(C_FIRST - 1), 2'(F_FIRST),
                                           1'b0, 2'(C_ADD), 3'(F_ADD), 2'b00};

  // Values after reset.
  localparam logic [ET_W-1:0] ET_RESET = '0;
  localparam logic [SYNTH_W-1:0] ACC_RESET = '0;
  localparam logic [TC_W-1:0] TC_RESET = 6'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [PRE_W-1:0] PRE_RESET = 16'h0000;

  // States of the interval filter.
  typedef enum logic [1:0] {
    JIT_IDLE = 2'b00,
    JIT_FIRST = 2'b01,
    JIT_TRACK = 2'b10
  } cuc_jit_state_t;

endpackage

//--- rtl/cuc_synth_if.sv
// Carries the rate increment to the synthesizer and its tick back.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface cuc_synth_if;
  import cuc_pkg::*;

  logic [SYNTH_W-1:0] inc;
  logic tick;

  modport rate (input inc, output tick);
  modport timer (output inc, input tick);
endinterface

//--- rtl/cuc_rate_synth.sv
// Phase accumulating rate synthesizer that ticks on every wrap.
// Assumes the increment is stable logic on the same clock.
`timescale 1ns/1ns
module cuc_rate_synth (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Increment in, tick out.
  cuc_synth_if.rate sif
);
  import cuc_pkg::*;

  logic [SYNTH_W-1:0] acc_reg;
  logic [SYNTH_W-1:0] acc_next;
  logic tick_reg;
  logic tick_next;
  wire [SYNTH_W:0] acc_sum;

  // The carry out of the sum is the wrap of the accumulator.
  assign acc_sum = {1'b0, acc_reg} + {1'b0, sif.inc}; // [R2]
  assign acc_next = acc_sum[SYNTH_W-1:0];
  assign tick_next = acc_sum[SYNTH_W]; // [R3]
  assign sif.tick = tick_reg;

  // Accumulator steps every cycle; the tick stands one cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_reg <= ACC_RESET;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end
endmodule

//--- bench/cuc_etg_assertions.sv
// Port checks for the elapsed time generator, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module cuc_etg_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Settings.
  input wire logic [cuc_pkg::SYNTH_W-1:0] synth_inc,
  input wire logic [cuc_pkg::ET_W-1:0] et_inc,
  input wire logic [cuc_pkg::MAP_W-1:0] mapping,
  input wire logic master_en,
  input wire logic load_time,
  input wire logic [cuc_pkg::ET_W-1:0] load_value,
  // Outputs watched.
  input wire logic tc_tx_strobe,
  input wire logic [cuc_pkg::TC_W-1:0] tc_tx_value,
  input wire logic [cuc_pkg::ET_W-1:0] elapsed_time,
  input wire logic [cuc_pkg::PRE_W-1:0] datation_width_field,
  input wire logic initialized,
  input wire logic synth_tick,
  input wire logic [cuc_pkg::MAP_W-1:0] mapping_used
);
  import cuc_pkg::*;
  logic [SYNTH_W-1:0] acc_reg;
  logic carry_reg;
  logic [SYNTH_W:0] sum_next;
  logic [ET_W-1:0] low_bits;
  logic [TC_W-1:0] field;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow accumulator, so the tick is tied to the carry rather than to its own past.
  assign sum_next = {1'b0, acc_reg} + {1'b0, synth_inc};
  always_ff @(posedge clk) begin
    acc_reg <= reset ? '0 : sum_next[SYNTH_W-1:0];
    carry_reg <= reset ? 1'b0 : sum_next[SYNTH_W];
  end
  // Bits below the code field, and the field itself.
  assign low_bits = elapsed_time << (ET_W - FINE_W + int'(mapping_used));
  assign field = TC_W'(elapsed_time >> (FINE_W - int'(mapping_used)));
  a_hold_no_tick: assert property (
    !load_time && !synth_tick |=> $stable(elapsed_time)) else $error("time moved without tick");
  a_tick_on_wrap: assert property (
    synth_tick == carry_reg) else $error("tick not on wrap");
  a_step_by_inc: assert property (
    synth_tick && initialized && !load_time |=> elapsed_time == ET_W'($past(elapsed_time) + $past(et_inc)))
    else $error("bad step");
  a_load_sets_time: assert property (
    load_time |=> elapsed_time == $past(load_value) && initialized) else $error("bad load");
  a_idle_before_load: assert property (
    !initialized && !load_time |=> elapsed_time == '0 && !initialized) else $error("stepped before load");
  a_preamble_value: assert property (
    !$past(reset) |-> datation_width_field == 16'haf00) else $error("bad preamble");
  a_code_needs_master: assert property (
    tc_tx_strobe |-> $past(master_en) && $past(initialized)) else $error("code while not master");
  a_code_on_edge: assert property (
    tc_tx_strobe |-> $past(low_bits) == '0 && tc_tx_value == $past(field)) else $error("bad code");
  a_map_clamped: assert property (
    mapping_used == ((mapping > 5'h18) ? 5'h18 : mapping)) else $error("mapping not clamped");
  c_code: cover property (tc_tx_strobe);
  c_step: cover property (synth_tick && initialized);
  c_load: cover property (load_time ##1 initialized);
endmodule

bind cuc_elapsed_time_generator cuc_etg_checker u_checker (.clk(clk), .reset(reset), .synth_inc(synth_inc),
  .et_inc(et_inc), .mapping(mapping), .master_en(master_en), .load_time(load_time), .load_value(load_value),
  .tc_tx_strobe(tc_tx_strobe), .tc_tx_value(tc_tx_value), .elapsed_time(elapsed_time),
  .datation_width_field(datation_width_field), .initialized(initialized), .synth_tick(synth_tick),
  .mapping_used(mapping_used));

//--- bench/cuc_link_node.sv
// Link node model: counts time-codes from the device and sends its own at a set spacing.
// Assumes the bench sets the spacing; zero keeps it silent.
`timescale 1ns/1ns
module cuc_link_node (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Spacing of received codes in cycles.
  input wire logic [31:0] gap,
  // Codes from the device.
  input wire logic tc_tx_strobe,
  // Codes toward the device, and a tally of those taken.
  output logic tc_rx_strobe = 1'b0,
  output logic [31:0] codes
);
  logic [31:0] cnt_reg;
  // A strobe every gap cycles; a larger gap set mid-count stretches the current interval.
  always @(posedge clk) begin
    if (reset || gap == 0) begin
      tc_rx_strobe <= 1'b0;
      cnt_reg <= '0;
    end else begin
      tc_rx_strobe <= cnt_reg >= gap - 1;
      cnt_reg <= (cnt_reg >= gap - 1) ? '0 : cnt_reg + 1;
    end
  end
  // Sends its own codes only once the bench has disabled the device master, so it never acts as a second master.
  // It is the only target and takes no remote writes, so the master's write-before-code
  // and one-write-per-target duties are trivially kept here.
  always @(posedge clk) begin
    codes <= reset ? '0 : codes + 32'(tc_tx_strobe);
  end
endmodule

//--- bench/cuc_elapsed_time_generator_bench.sv
// Self-checking bench for the elapsed time generator with a link node model.
// Assumes the design and the checker bind are compiled first.
`timescale 1ns/1ns
module cuc_elapsed_time_generator_bench;
  import cuc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [SYNTH_W-1:0] synth_inc = '0, m_acc;
  logic [ET_W-1:0] et_inc = '0, load_value = '0, elapsed_time, m_et, m_prev;
  logic [MAP_W-1:0] mapping = '0, mapping_used;
  logic master_en = 1'b0, load_time = 1'b0, tc_rx_strobe, tc_tx_strobe, initialized, synth_tick;
  logic filter_locked, m_tick, m_init, m_str, hit;
  logic [TC_W-1:0] tc_tx_value, m_val;
  logic [PRE_W-1:0] datation_width_field;
  logic [31:0] avg_interval, gap = '0, codes, sent, ticks, ticks_start;
  logic corr_tick;
  int errors = 0, num_checks = 0, cycles = 0, sh;

  always #5 clk = ~clk;

  cuc_elapsed_time_generator dut (.clk(clk), .reset(reset), .synth_inc(synth_inc), .et_inc(et_inc),
    .mapping(mapping), .master_en(master_en), .load_time(load_time), .load_value(load_value),
    .tc_rx_strobe(tc_rx_strobe), .tc_tx_strobe(tc_tx_strobe), .tc_tx_value(tc_tx_value),
    .elapsed_time(elapsed_time), .datation_width_field(datation_width_field), .initialized(initialized),
    .synth_tick(synth_tick), .mapping_used(mapping_used), .avg_interval(avg_interval),
    .filter_locked(filter_locked), .corr_tick(corr_tick));
  cuc_link_node node (.clk(clk), .reset(reset), .gap(gap), .tc_tx_strobe(tc_tx_strobe),
    .tc_rx_strobe(tc_rx_strobe), .codes(codes));

  function automatic int shf(input logic [MAP_W-1:0] m);
    return FINE_W - ((m > 24) ? 24 : int'(m));
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic run(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic load(input logic [ET_W-1:0] v);
    load_value = v;
    load_time = 1'b1;
    run(1);
    load_time = 1'b0;
  endtask

  // Reference model of accumulator, counter and code source, one edge at a time.
  always @(posedge clk) begin
    sh = shf(mapping);
    hit = master_en && m_init && (m_et << (ET_W - sh)) == '0 && TC_W'(m_et >> sh) != TC_W'(m_prev >> sh);
    if (reset) begin
      {m_tick, m_acc, m_init, m_str, m_et, m_prev, m_val, sent} <= '0;
    end else begin
      {m_tick, m_acc} <= {1'b0, m_acc} + {1'b0, synth_inc};
      m_init <= m_init | load_time;
      m_et <= load_time ? load_value : (m_tick && m_init) ? m_et + et_inc : m_et;
      m_prev <= m_et;
      m_str <= hit;
      m_val <= hit ? TC_W'(m_et >> sh) : m_val;
      sent <= sent + 32'(hit);
    end
  end

  // Tally of local corrected ticks, so the divider period can be checked.
  always @(posedge clk) begin
    ticks <= reset ? 32'h0000_0000 : ticks + 32'(corr_tick);
  end

  // Compare every settled cycle; the cycle ceiling cuts a hang short.
  always @(negedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
    if (!reset) begin
      chk(elapsed_time, m_et);
      chk(synth_tick, m_tick);
      chk(initialized, m_init);
      chk(tc_tx_strobe, m_str);
      chk(tc_tx_value, m_val);
    end
  end

  // Corner cases first, then random settings, then the interval filter.
  initial begin
    sh = $urandom(72687);
    run(16);
    reset = 1'b0;
    run(1);
    chk(datation_width_field, 16'haf00);
    synth_inc = 32'hffff_ffff;
    et_inc = 56'h00_0000_0000_0001;
    run(20);
    load(56'hff_ffff_ffff_fffe);
    run(6);
    master_en = 1'b1;
    load(56'h00_0000_00ff_fff0);
    run(40);
    for (int i = 0; i < 14; i++) begin
      master_en = 1'b0;
      mapping = (i == 0) ? 5'h1f : MAP_W'($urandom_range(31));
      reset = (i == 6);
      run(2);
      reset = 1'b0;
      synth_inc = $urandom | 32'h4000_0000;
      et_inc = 56'(1) << ((shf(mapping) > 2) ? shf(mapping) - $urandom_range(2) : 0);
      master_en = ($urandom_range(3) != 0);
      if (i == 7 || $urandom_range(2) == 0) load(ET_W'({$urandom, $urandom}));
      run(200);
    end
    master_en = 1'b0;
    gap = 10;
    run(40);
    chk(avg_interval, 32'h0000_000a);
    chk(filter_locked, 1'b1);
    gap = 50;
    ticks_start = ticks;
    run(55);
    chk(avg_interval, 32'h0000_000f);
    chk(ticks - ticks_start, 32'h0000_0006);
    chk(codes, sent);
    test_done();
  end
endmodule
